//--- rtl/modbus_srv_pkg.sv
// Shared constants and types of the serial command server.
// Assumes a byte-wide receive stream with an end-of-frame strobe on sys_clk.
`default_nettype none
package modbus_srv_pkg;
    // ****************************************
    // Function and exception codes
    // ****************************************
    localparam logic [7:0] FC_READ_BITS = 8'h02;   // Read discrete status bits
    localparam logic [7:0] FC_READ_HOLD = 8'h03;   // Read holding registers
    localparam logic [7:0] FC_READ_INPUT = 8'h04;  // Read input registers
    localparam logic [7:0] FC_WRITE_COIL = 8'h05;  // Write one soft input bit
    localparam logic [7:0] ERR_FLAG = 8'h80;       // Added to the code on failure
    localparam logic [7:0] EXC_FUNC = 8'h01;       // Unsupported function
    localparam logic [7:0] EXC_ADDR = 8'h02;       // Address out of map
    localparam logic [7:0] EXC_VALUE = 8'h03;      // Bad quantity or value
    localparam logic [7:0] EXC_NONE = 8'h00;       // No exception
    // ****************************************
    // Field limits and values
    // ****************************************
    localparam logic [15:0] QTY_MIN = 16'h0001;    // Fewest registers or bits
    localparam logic [15:0] QTY_MAX = 16'h007D;    // Most registers
    localparam logic [15:0] COIL_ON = 16'hFF00;    // Bit on
    localparam logic [15:0] COIL_OFF = 16'h0000;   // Bit off
    localparam logic [15:0] DISC_COUNT = 16'h0040; // Discrete bits mapped
    localparam logic [15:0] COIL_COUNT = 16'h0020; // Soft input bits
    localparam logic [3:0] REQ_LEN = 4'h8;         // Every supported request
    localparam logic [3:0] MIN_LEN = 4'h4;         // Node, code, two CRC bytes
    localparam logic [7:0] BASE_LEN = 8'h05;       // Node, code, count/exc, CRC
    localparam logic [7:0] WRITE_LEN = 8'h08;      // Echo of a bit write
    localparam logic [7:0] CRC_LEN = 8'h02;        // Trailing CRC bytes
    localparam logic [6:0] BYTE_ROUND = 7'h07;     // Rounds bits up to bytes
    // ****************************************
    // CRC and register map
    // ****************************************
    localparam logic [15:0] CRC_INIT = 16'hFFFF;   // Start value
    localparam logic [15:0] CRC_POLY = 16'hA001;   // Reflected polynomial
    localparam logic [15:0] CRC_GOOD = 16'h0000;   // Residue over a good frame
    localparam logic [15:0] ADDR_MOTOR = 16'h2000;    // motor_type_code
    localparam logic [15:0] ADDR_ENC_KIND = 16'h2001; // encoder_kind
    localparam logic [15:0] ADDR_PULSE_LO = 16'h2002; // encoder_pulses_per_rev low
    localparam logic [15:0] ADDR_PULSE_HI = 16'h2003; // encoder_pulses_per_rev high
    localparam logic [15:0] ADDR_CONTACTS = 16'h2121; // drive_output_contacts_1
    localparam logic [15:0] ADDR_SPEED = 16'h2600;    // present_speed
    // ****************************************
    // Sequencer states
    // ****************************************
    typedef enum logic [1:0] {
        ST_LISTEN = 2'b00,
        ST_DECIDE = 2'b01,
        ST_SEND = 2'b10
    } srv_state_type;
endpackage
`default_nettype wire

//--- rtl/srv_links_if.sv
// Carriers between the server and its CRC and register helpers.
// Assumes all users sit on sys_clk.
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// CRC feed
// ****************************************
interface crc_link_if;
    logic clear;         // Restart at the initial value
    logic strobe;        // Fold data in
    logic [7:0] data;    // Byte to fold
    logic [15:0] value;  // Running CRC
    modport user(output clear, output strobe, output data, input value);
    modport unit(input clear, input strobe, input data, output value);
endinterface
// ****************************************
// Register window lookup
// ****************************************
interface reg_link_if;
    logic input_map;     // Input map instead of holding map
    logic [15:0] start;  // First register asked for
    logic [15:0] qty;    // Registers asked for
    logic [15:0] addr;   // Register to read now
    logic [15:0] word;   // Its contents
    logic range_ok;      // Whole block is mapped
    modport user(output input_map, output start, output qty, output addr,
                 input word, input range_ok);
    modport regs(input input_map, input start, input qty, input addr,
                 output word, output range_ok);
endinterface
`default_nettype wire

//--- rtl/crc16_unit.sv
// Byte-serial CRC-16 of the serial frames, one byte per cycle.
// Assumes the user strobes each byte once, in frame order.
`timescale 1ns/1ns
`default_nettype none
module crc16_unit (
    input wire logic sys_clk,     // System clock
    input wire logic rst_n,       // Async reset, active low
    crc_link_if.unit link         // Feed and result
);
    import modbus_srv_pkg::*;

    logic [15:0] crc_reg; // Running value

    // Folds one byte in, low bit first
    function automatic logic [15:0] fold(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // Clear wins over a byte in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_reg <= CRC_INIT;
        end else if (link.clear) begin
            crc_reg <= CRC_INIT;
        end else if (link.strobe) begin
            crc_reg <= fold(crc_reg, link.data);
        end
    end

    assign link.value = crc_reg;
endmodule
`default_nettype wire

//--- rtl/reg_window.sv
// Register map of the drive parameters and the block range check.
// Assumes parameter values arrive as levels from logic on sys_clk.
`timescale 1ns/1ns
`default_nettype none
module reg_window (
    input wire logic [15:0] motor_type_code,        // Motor type
    input wire logic [15:0] encoder_kind,           // Encoder type
    input wire logic [31:0] encoder_pulses_per_rev, // Pulses per turn
    input wire logic [15:0] contacts_word,          // Output contacts 1
    input wire logic [15:0] present_speed,          // Present speed
    reg_link_if.regs link                           // Lookup port
);
    import modbus_srv_pkg::*;

    logic [16:0] last_addr; // Last register of the block

    assign last_addr = {1'b0, link.start} + {1'b0, link.qty} - 17'h0_0001;

    // True when the whole block lies in one mapped run; a zero count passes for any start from lo to hi + 1
    function automatic logic fits(input logic [15:0] lo, input logic [15:0] hi);
        return (link.start >= lo) && (last_addr <= {1'b0, hi});
    endfunction

    // Holding map is the parameter run and speed; input map the contacts and speed
    assign link.range_ok = link.input_map ?
        (fits(ADDR_CONTACTS, ADDR_CONTACTS) || fits(ADDR_SPEED, ADDR_SPEED)) :
        (fits(ADDR_MOTOR, ADDR_PULSE_HI) || fits(ADDR_SPEED, ADDR_SPEED));

    // Word lookup; a 32-bit value puts its low word at the lower address
    always_comb begin
        link.word = 16'h0000;
        case (link.addr)
            ADDR_MOTOR: link.word = link.input_map ? 16'h0000 : motor_type_code;
            ADDR_ENC_KIND: link.word = link.input_map ? 16'h0000 : encoder_kind;
            ADDR_PULSE_LO: begin
                link.word = link.input_map ? 16'h0000 : encoder_pulses_per_rev[15:0];
            end
            ADDR_PULSE_HI: begin
                link.word = link.input_map ? 16'h0000 : encoder_pulses_per_rev[31:16];
            end
            ADDR_CONTACTS: link.word = link.input_map ? contacts_word : 16'h0000;
            ADDR_SPEED: link.word = present_speed;
            default: link.word = 16'h0000;
        endcase
    end
endmodule
`default_nettype wire

//--- rtl/modbus_register_coil_server.sv
// Slave command handler of the drive serial port: decodes a request
// frame, answers reads of status bits and registers, writes soft inputs.
// Assumes byte framing and silence detection upstream on sys_clk, and a
// transmitter that takes bytes by valid and ready.
//
// Overview of operation
// - Packed status bits: first address in bit 0
// - Function 03 returns holding register words
// - Function 03 quantity must be 1 to 125
// - Register read reply: code, count 2N, words high first
// - Function 03 failure: 0x83 and exception code
// - Function 04 returns input registers, quantity 0..0x7D
// - Function 04 failure: 0x84 and exception code
// - Output contact word: one bit per contact
// - Function 05 switches one input bit
// - Write reply echoes address and value
// - Function 05 failure: 0x85 and exception code
// - Written bits drive the soft input contacts
`timescale 1ns/1ns
`default_nettype none
module modbus_register_coil_server (
    input wire logic sys_clk,                       // System clock, 250 MHz
    input wire logic rst_n,                         // Async reset, active low
    input wire logic [7:0] node_id,                 // Own node identifier
    input wire logic [7:0] rx_byte,                 // Received byte
    input wire logic rx_valid,                      // Received byte strobe
    input wire logic rx_frame_end,                  // Frame closed by silence
    output logic [7:0] tx_byte,                     // Byte to send
    output logic tx_valid,                          // Byte ready to send
    output logic tx_last,                           // Byte ends the reply
    input wire logic tx_ready,                      // Transmitter takes byte
    input wire logic [15:0] motor_type_code,        // Motor type
    input wire logic [15:0] encoder_kind,           // Encoder type
    input wire logic [31:0] encoder_pulses_per_rev, // Pulses per turn
    input wire logic [15:0] present_speed,          // Present speed
    input wire logic [31:0] out_contacts,           // Output contacts, 1 = high
    output logic [31:0] soft_inputs                 // Soft input contacts
);
    import modbus_srv_pkg::*;

    // ****************************************
    // Storage and carriers
    // ****************************************
    srv_state_type state_reg;      // Sequencer state
    logic [7:0] frame_mem [0:7];   // Request bytes in arrival order
    logic [3:0] rx_cnt_reg;        // Bytes seen, saturates past a full request
    logic [31:0] coil_reg;         // Soft input bits
    logic [7:0] exc_reg;           // Exception of the reply, zero if none
    logic [7:0] len_reg;           // Reply length in bytes
    logic [7:0] idx_reg;           // Index of the byte on the output
    logic [7:0] tx_byte_reg;       // Byte on the output
    logic tx_valid_reg;            // Output holds a byte

    crc_link_if rx_crc();          // Check of incoming frames
    crc_link_if tx_crc();          // Generation for replies
    reg_link_if regs();            // Register lookup

    // ****************************************
    // Request fields
    // ****************************************
    logic [7:0] fc;                // Function code
    logic [15:0] start;            // Start or output address
    logic [15:0] qty;              // Quantity or output value
    logic [7:0] exc_c;             // Exception found in the request
    logic [7:0] len_c;             // Reply length for the request
    logic accept;                  // Request earns a reply
    logic unsupported;             // Code not served

    assign fc = frame_mem[1];
    assign start = {frame_mem[2], frame_mem[3]};
    assign qty = {frame_mem[4], frame_mem[5]};

    // Frame checks and reply sizing, looked at in the decide state only
    always_comb begin
        exc_c = EXC_NONE;
        len_c = BASE_LEN;
        unsupported = 1'b0;
        case (fc)
            FC_READ_BITS: begin
                if (qty < QTY_MIN || qty > DISC_COUNT) begin
                    exc_c = EXC_VALUE;
                end else if ({1'b0, start} + {1'b0, qty} > {1'b0, DISC_COUNT}) begin
                    exc_c = EXC_ADDR;
                end
                len_c = BASE_LEN + {4'h0, 4'((qty[6:0] + BYTE_ROUND) >> 3)};
            end
            FC_READ_HOLD: begin
                if (qty < QTY_MIN || qty > QTY_MAX) begin
                    exc_c = EXC_VALUE;
                end else if (!regs.range_ok) begin
                    exc_c = EXC_ADDR;
                end
                len_c = BASE_LEN + {qty[6:0], 1'b0};
            end
            FC_READ_INPUT: begin
                if (qty > QTY_MAX) begin
                    exc_c = EXC_VALUE;
                end else if (qty != 16'h0000 && !regs.range_ok) begin
                    exc_c = EXC_ADDR;
                end
                len_c = BASE_LEN + {qty[6:0], 1'b0};
            end
            FC_WRITE_COIL: begin
                if (qty != COIL_ON && qty != COIL_OFF) begin
                    exc_c = EXC_VALUE;
                end else if (start >= COIL_COUNT) begin
                    exc_c = EXC_ADDR;
                end
                len_c = WRITE_LEN;
            end
            default: begin
                exc_c = EXC_FUNC;
                unsupported = 1'b1;
            end
        endcase
        if (exc_c != EXC_NONE) begin
            len_c = BASE_LEN;
        end
    end

    // Own node, good residue, and a full request unless the code is unknown
    assign accept = (frame_mem[0] == node_id) && (rx_crc.value == CRC_GOOD) &&
                    (rx_cnt_reg >= MIN_LEN) &&
                    ((rx_cnt_reg == REQ_LEN) || unsupported);

    // ****************************************
    // Reply byte builder
    // ****************************************
    logic [7:0] k;                 // Index of the byte to load next
    logic [7:0] p;                 // Index within the payload
    logic [7:0] d;                 // Index within the data bytes
    logic [6:0] bit_pos;           // First discrete bit of this byte
    logic [6:0] bits_left;         // Bits still owed
    logic [63:0] disc_vec;         // Soft inputs then output contacts
    logic [63:0] disc_win;         // Shifted to the wanted bit
    logic [7:0] bits_byte;         // Packed status bits
    logic [7:0] byte_c;            // Byte to load
    logic load;                    // Load the output register
    logic is_last;                 // Output holds the final byte
    logic done;                    // Final byte taken

    assign k = (state_reg == ST_SEND) ? idx_reg + 8'h01 : 8'h00;
    assign p = k - CRC_LEN;
    assign d = p - 8'h01;
    assign disc_vec = {out_contacts, coil_reg};
    assign bit_pos = start[6:0] + {d[3:0], 3'h0};
    assign bits_left = qty[6:0] - {d[3:0], 3'h0};
    assign disc_win = disc_vec >> bit_pos;

    // Lower address in bit 0; bits past the count read as zero
    always_comb begin
        for (int j = 0; j < 8; j++) begin
            bits_byte[j] = disc_win[j] && (7'(j) < bits_left);
        end
    end

    // Lookup for register reads, two bytes per register in rising order
    assign regs.input_map = (fc == FC_READ_INPUT);
    assign regs.start = start;
    assign regs.qty = qty;
    assign regs.addr = start + {9'h000, d[7:1]};

    // Selects each reply byte by position
    always_comb begin
        if (k == 8'h00) begin
            byte_c = node_id;
        end else if (k == len_reg - 8'h01) begin
            byte_c = tx_crc.value[15:8];
        end else if (k == len_reg - CRC_LEN) begin
            byte_c = tx_crc.value[7:0];
        end else if (k == 8'h01) begin
            byte_c = (exc_reg != EXC_NONE) ? (fc | ERR_FLAG) : fc;
        end else if (exc_reg != EXC_NONE) begin
            byte_c = exc_reg;
        end else if (fc == FC_WRITE_COIL) begin
            byte_c = frame_mem[3'(p[2:0] + 3'h2)];
        end else if (p == 8'h00) begin
            byte_c = len_reg - BASE_LEN;
        end else if (fc == FC_READ_BITS) begin
            byte_c = bits_byte;
        end else begin
            byte_c = d[0] ? regs.word[7:0] : regs.word[15:8];
        end
    end

    assign is_last = (idx_reg == len_reg - 8'h01);
    assign load = (state_reg == ST_SEND) && (!tx_valid_reg || (tx_ready && !is_last));
    assign done = (state_reg == ST_SEND) && tx_valid_reg && tx_ready && is_last;

    // ****************************************
    // CRC feeds
    // ****************************************
    // Receive side folds every byte, CRC bytes too, so a good frame leaves zero
    assign rx_crc.clear = (state_reg == ST_DECIDE);
    assign rx_crc.strobe = (state_reg == ST_LISTEN) && rx_valid;
    assign rx_crc.data = rx_byte;
    // Send side folds every byte before the CRC itself
    assign tx_crc.clear = (state_reg == ST_DECIDE);
    assign tx_crc.strobe = load && (k < len_reg - CRC_LEN);
    assign tx_crc.data = byte_c;

    crc16_unit u_rx_crc (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .link(rx_crc)
    );

    crc16_unit u_tx_crc (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .link(tx_crc)
    );

    reg_window u_regs (
        .motor_type_code(motor_type_code),
        .encoder_kind(encoder_kind),
        .encoder_pulses_per_rev(encoder_pulses_per_rev),
        .contacts_word(out_contacts[15:0]),
        .present_speed(present_speed),
        .link(regs)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    // Bytes arriving while a reply is out are dropped: the port is half duplex
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_LISTEN;
        end else begin
            unique case (state_reg)
                ST_LISTEN: begin
                    if (rx_frame_end && (rx_cnt_reg != 4'h0 || rx_valid)) begin
                        state_reg <= ST_DECIDE;
                    end
                end
                ST_DECIDE: begin
                    // Frames for others or with bad CRC vanish silently
                    state_reg <= accept ? ST_SEND : ST_LISTEN;
                end
                ST_SEND: begin
                    if (done) begin
                        state_reg <= ST_LISTEN;
                    end
                end
                default: state_reg <= ST_LISTEN;
            endcase
        end
    end

    // Frame capture; bytes past a full request are counted, not kept
    always_ff @(posedge sys_clk) begin
        if (state_reg == ST_LISTEN && rx_valid && rx_cnt_reg < REQ_LEN) begin
            frame_mem[rx_cnt_reg[2:0]] <= rx_byte;
        end
    end

    // Byte count of the frame being heard
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_cnt_reg <= 4'h0;
        end else if (state_reg == ST_DECIDE) begin
            rx_cnt_reg <= 4'h0;
        end else if (state_reg == ST_LISTEN && rx_valid && rx_cnt_reg <= REQ_LEN) begin
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
        end
    end

    // Reply shape, fixed for the whole reply
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            exc_reg <= EXC_NONE;
            len_reg <= BASE_LEN;
        end else if (state_reg == ST_DECIDE) begin
            exc_reg <= exc_c;
            len_reg <= len_c;
        end
    end

    // Soft input bits; only the two legal values ever reach here
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            coil_reg <= 32'h0000_0000;
        end else if (state_reg == ST_DECIDE && accept && fc == FC_WRITE_COIL &&
                     exc_c == EXC_NONE) begin
            coil_reg[start[4:0]] <= (qty == COIL_ON);
        end
    end

    // Output byte register; index starts one below zero so the first load is 0
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_reg <= 8'hFF;
            tx_byte_reg <= 8'h00;
            tx_valid_reg <= 1'b0;
        end else if (state_reg == ST_DECIDE) begin
            idx_reg <= 8'hFF;
        end else if (load) begin
            idx_reg <= k;
            tx_byte_reg <= byte_c;
            tx_valid_reg <= 1'b1;
        end else if (done) begin
            tx_valid_reg <= 1'b0;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign tx_byte = tx_byte_reg;
    assign tx_valid = tx_valid_reg;
    assign tx_last = tx_valid_reg && is_last;
    assign soft_inputs = coil_reg;
endmodule
`default_nettype wire

//--- verif/srv_master_model.sv
// Behavioural serial master facing the command server.
// Assumes the bench supplies whole frames with their CRC attached.
`timescale 1ns/1ns
`default_nettype none
module srv_master_model (
    input wire logic sys_clk,   // System clock
    input wire logic stall,     // Holds off reply bytes
    output logic [7:0] rx_byte, // Byte to the server
    output logic rx_valid,      // Byte strobe
    output logic rx_frame_end,  // Silence after a frame
    output logic tx_ready       // Takes a reply byte
);
    initial {rx_byte, rx_valid, rx_frame_end} = '0;
    // A slow master is modelled by random stalls on the reply side
    assign tx_ready = !stall;
    // One byte per cycle, then the silence strobe
    task automatic send(input logic [7:0] f[$]);
        foreach (f[i]) begin
            @(posedge sys_clk) #1;
            rx_byte = f[i];
            rx_valid = 1'b1;
        end
        @(posedge sys_clk) #1;
        rx_byte = ~rx_byte; // Idle line must not repeat the last byte
        rx_valid = 1'b0;
        rx_frame_end = 1'b1;
        @(posedge sys_clk) #1;
        rx_frame_end = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- verif/modbus_register_coil_server_properties.sv
// Timing checks on the reply port and the soft inputs of the server.
// Assumes a bind onto the server's top module.
`timescale 1ns/1ns
`default_nettype none
module srv_props (
    input wire logic sys_clk,           // System clock
    input wire logic rst_n,             // Async reset, active low
    input wire logic [7:0] node_id,     // Own node
    input wire logic rx_valid,          // Byte strobe
    input wire logic rx_frame_end,      // Frame closed
    input wire logic [7:0] tx_byte,     // Reply byte
    input wire logic tx_valid,          // Reply byte valid
    input wire logic tx_last,           // Final reply byte
    input wire logic tx_ready,          // Byte taken
    input wire logic [31:0] soft_inputs // Soft input contacts
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    chk_hold_byte: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
        else $error("reply byte changed before taken");
    chk_node_first: assert property ($rose(tx_valid) |-> tx_byte == node_id)
        else $error("reply does not open with node");
    chk_first_not_last: assert property ($rose(tx_valid) |-> !tx_last)
        else $error("reply too short");
    chk_reply_delay: assert property ($rose(tx_valid) |-> $past(rx_frame_end, 3))
        else $error("reply without closed frame");
    chk_last_valid: assert property (tx_last |-> tx_valid)
        else $error("last flag without byte");
    chk_last_closes: assert property (tx_last && tx_ready |=> !tx_valid)
        else $error("bytes after the last one");
    chk_quiet_rx: assert property (rx_valid |-> !tx_valid)
        else $error("reply while a frame arrives");
    chk_soft_cause: assert property ($changed(soft_inputs) |->
        $past(rx_frame_end, 2) || $past(rx_frame_end, 3))
        else $error("soft inputs changed without a frame");
    chk_soft_one_bit: assert property ($changed(soft_inputs) |->
        $onehot(soft_inputs ^ $past(soft_inputs)))
        else $error("more than one soft input changed");
endmodule
`default_nettype wire

//--- verif/modbus_register_coil_server_test.sv
// Self-checking bench of the serial command server.
// Assumes the master model and the checker files compiled before it.
`timescale 1ns/1ns
`default_nettype none
module modbus_register_coil_server_test;
    import modbus_srv_pkg::*;
    logic sys_clk = 0, rst_n = 0, stall = 0;
    logic [7:0] rx_byte, tx_byte, seed = 8'h56, sp_hi, sp_lo;
    logic rx_valid, rx_frame_end, tx_valid, tx_last, tx_ready;
    logic [31:0] soft_inputs, contacts;
    logic [7:0] exp[$];
    int fails = 0, n_tests = 0;
    srv_master_model i_master (.sys_clk(sys_clk), .stall(stall), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .rx_frame_end(rx_frame_end), .tx_ready(tx_ready));
    modbus_register_coil_server i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .node_id(8'h01),
        .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_frame_end(rx_frame_end),
        .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
        .motor_type_code(16'h000D), .encoder_kind(16'h0002),
        .encoder_pulses_per_rev(32'h0008_0000), .present_speed({sp_hi, sp_lo}),
        .out_contacts(contacts), .soft_inputs(soft_inputs));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Bench's own CRC, low byte sent first
    function automatic logic [15:0] crc(input logic [7:0] f[$]);
        crc = CRC_INIT;
        foreach (f[i]) begin
            crc ^= {8'h00, f[i]};
            repeat (8) crc = crc[0] ? (crc >> 1) ^ CRC_POLY : crc >> 1;
        end
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, want, seen);
        end
    endtask
    task automatic test_done();
        if (fails == 0 && n_tests > 0 && exp.size() == 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Sends a six-byte request and notes the expected reply, if any
    task automatic xfer(input logic [47:0] q, input logic [87:0] r, input int nr);
        logic [7:0] f[$];
        logic [7:0] g[$];
        logic [15:0] c;
        for (int i = 5; i >= 0; i--) f.push_back(q[8*i+:8]);
        for (int i = nr - 1; i >= 0; i--) g.push_back(r[8*i+:8]);
        c = crc(f);
        f = {f, c[7:0], c[15:8]};
        c = crc(g);
        if (nr > 0) exp = {exp, g, c[7:0], c[15:8]};
        i_master.send(f);
        for (int k = 0; k < 300 && exp.size() > 0; k++) @(posedge sys_clk);
        repeat (8) @(posedge sys_clk);
    endtask
    initial forever #2 sys_clk = ~sys_clk;
    // Random stalls of the master, changed just after each edge
    always @(posedge sys_clk) begin
        #1;
        seed = lfsr(seed);
        stall = seed[0];
    end
    // Every byte taken is matched against the oldest note
    always @(posedge sys_clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            check("tx_last", {31'h0, tx_last}, {31'h0, exp.size() == 1});
            check("tx_byte", tx_byte, exp.size() > 0 ? exp.pop_front() : ~tx_byte);
        end
    end
    // Watchdog far beyond the expected run length
    initial begin
        #200000;
        fails++;
        test_done();
    end
    initial begin
        sp_hi = lfsr(seed);
        sp_lo = lfsr(sp_hi);
        contacts = {lfsr(sp_lo), sp_lo, 16'h0499};
        repeat (16) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        check("soft_inputs", soft_inputs, 32'h0000_0000);
        xfer(48'h0103_2600_0001, {24'h01_0302, sp_hi, sp_lo}, 5);
        xfer(48'h0103_2000_0004, 88'h01_0308_000D_0002_0000_0008, 11);
        xfer(48'h0104_2121_0001, 40'h01_0402_0499, 5);
        xfer(48'h0104_2121_0000, 24'h01_0400, 3);
        xfer(48'h0104_2121_007E, 24'h01_8403, 3);
        xfer(48'h0103_2600_0000, 24'h01_8303, 3);
        xfer(48'h0103_2600_007D, 24'h01_8302, 3);
        xfer(48'h0102_0033_0003, {24'h01_0201, 5'h00, contacts[21:19]}, 4);
        xfer(48'h0105_0005_FF00, 48'h0105_0005_FF00, 6);
        check("soft_inputs", soft_inputs, 32'h0000_0020);
        xfer(48'h0105_0005_0000, 48'h0105_0005_0000, 6);
        check("soft_inputs", soft_inputs, 32'h0000_0000);
        xfer(48'h0105_0005_1234, 24'h01_8503, 3);
        xfer(48'h0105_0020_FF00, 24'h01_8502, 3);
        xfer(48'h0106_0005_0000, 24'h01_8601, 3);
        xfer(48'h0203_2600_0001, 88'h0, 0);
        test_done();
    end
endmodule
bind modbus_register_coil_server srv_props i_props (.sys_clk(sys_clk), .rst_n(rst_n),
    .node_id(node_id), .rx_valid(rx_valid), .rx_frame_end(rx_frame_end),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
    .soft_inputs(soft_inputs));
`default_nettype wire
